/* File: aos_pkg.sv */
// constants and types shared by the alu operand selection block
package aos_pkg;
    typedef logic [15:0] aos_word_t;
    // microword field positions (lsb) and widths
    localparam int UW_W = 64;
    localparam int FF_LSB = 59;
    localparam int FF_W = 4;
    localparam int MF_LSB = 58;
    localparam int CF_LSB = 56;
    localparam int CF_W = 2;
    localparam int DS_LSB = 54;
    localparam int DS_W = 2;
    localparam int SH_LSB = 47;
    localparam int SH_W = 3;
    localparam int BB_LSB = 43;
    localparam int AA_LSB = 39;
    localparam int IDX_W = 4;
    localparam int LA_LSB = 37;
    localparam int LB_LSB = 35;
    localparam int SEL_W = 2;
    localparam int LIT_LSB = 43;
    localparam int LIT_W = 16;
    localparam int FF_MODE_BIT = 1;
    // source select codes
    localparam logic [1:0] A_SRC_GPR = 2'h0;
    localparam logic [1:0] A_SRC_PC = 2'h1;
    localparam logic [1:0] A_SRC_SHL = 2'h2;
    localparam logic [1:0] A_SRC_SHR = 2'h3;
    localparam logic [1:0] B_SRC_GPR = 2'h0;
    localparam logic [1:0] B_SRC_SPECIAL = 2'h1;
    localparam logic [1:0] B_SRC_MASK = 2'h2;
    localparam logic [1:0] B_SRC_LITERAL = 2'h3;
    localparam logic [1:0] CARRY_ZERO = 2'h0;
    // special source group codes
    localparam logic [3:0] SP_OPERAND = 4'h0;
    localparam logic [3:0] SP_MEMORY_IN = 4'h1;
    localparam logic [3:0] SP_IO_IN = 4'h2;
    localparam logic [3:0] SP_FLAGS = 4'h3;
    localparam logic [3:0] SP_LOW_SIGNED = 4'h4;
    localparam logic [3:0] SP_HIGH_SIGNED = 4'h5;
    localparam logic [3:0] SP_LOW_UNSIGNED = 4'h6;
    localparam logic [3:0] SP_LOW_TO_HIGH = 4'h7;
    localparam aos_word_t SP_RESERVED_VALUE = 16'h0000;
    // right-shift fill codes
    localparam logic [2:0] SHR_MUL_SIGN = 3'h0;
    localparam logic [2:0] SHR_BIT0 = 3'h1;
    localparam logic [2:0] SHR_BIT15 = 3'h2;
    localparam logic [2:0] SHR_OPL0 = 3'h3;
    localparam logic [2:0] SHR_ZERO = 3'h4;
    // left-shift low-bit codes
    localparam logic [1:0] SHL_ZERO = 2'h0;
    localparam logic [1:0] SHL_BIT15 = 2'h1;
    localparam logic [1:0] SHL_OPL15 = 2'h2;
    // register byte addresses
    localparam logic [7:0] OFS_GPR0 = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h40;
    localparam logic [7:0] OFS_OPERAND = 8'h44;
    localparam logic [7:0] OFS_MEMORY_IN = 8'h48;
    localparam logic [7:0] OFS_IO_IN = 8'h4C;
    localparam logic [7:0] OFS_FLAGS = 8'h50;
    localparam logic [7:0] OFS_INSTR = 8'h54;
    localparam logic [7:0] OFS_CONTROL = 8'h58;
    localparam logic [7:0] OFS_A_VIEW = 8'h5C;
    localparam logic [7:0] OFS_B_VIEW = 8'h60;
    localparam logic [7:0] OFS_RESULT_VIEW = 8'h64;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_MUL_SIGN = 1;
    localparam logic [1:0] CONTROL_RESET = 2'h1;
    localparam aos_word_t WORD_RESET = 16'h0000;
endpackage

/* File: aos_a_select.sv */
// a bus source selection with one-bit shift and fill choice
`timescale 1ns/10ps
module aos_a_select (
    // selection fields
    input wire logic [1:0] a_sel,
    input wire logic [2:0] move,
    input wire logic [1:0] b_sel,
    // sources
    input wire aos_pkg::aos_word_t reg_value,
    input wire aos_pkg::aos_word_t pc,
    input wire aos_pkg::aos_word_t operand,
    input wire logic mul_sign,
    // result
    output aos_pkg::aos_word_t a_bus
);
    import aos_pkg::*;

    // constants only forced while the b side is a plain source
    wire b_plain = ~b_sel[1];
    wire force_zero = b_plain && (move[1:0] == 2'h1);
    wire force_ones = b_plain && move[1];
    wire high_left = move[2] ? reg_value[15] : reg_value[14];
    // code 11 has no meaning; zero is the safe fill
    wire low_left = (move[1:0] == SHL_BIT15) ? reg_value[15] :
                    (move[1:0] == SHL_OPL15) ? operand[15] : 1'b0;
    wire fill_right = (move == SHR_MUL_SIGN) ? mul_sign :
                      (move == SHR_BIT0) ? reg_value[0] :
                      (move == SHR_BIT15) ? reg_value[15] :
                      (move == SHR_OPL0) ? operand[0] : 1'b0;
    wire aos_word_t plain = force_zero ? 16'h0000 :
                            force_ones ? 16'hFFFF : reg_value;
    assign a_bus = (a_sel == A_SRC_PC) ? pc :
                   (a_sel == A_SRC_SHL) ? {high_left, reg_value[13:0], low_left} :
                   (a_sel == A_SRC_SHR) ? {fill_right, reg_value[15:1]} : plain;
endmodule // aos_a_select

/* File: aos_b_select.sv */
// b bus source selection: register, special views, mask, literal
`timescale 1ns/10ps
module aos_b_select (
    // selection fields
    input wire logic [1:0] b_sel,
    input wire logic [3:0] b_index,
    input wire logic [15:0] constant_bits,
    // sources
    input wire aos_pkg::aos_word_t reg_value,
    input wire aos_pkg::aos_word_t operand,
    input wire aos_pkg::aos_word_t memory_in,
    input wire aos_pkg::aos_word_t io_in,
    input wire aos_pkg::aos_word_t flags,
    input wire aos_pkg::aos_word_t instr,
    // result
    output aos_pkg::aos_word_t b_bus
);
    import aos_pkg::*;

    // special source group views of the operand latch
    wire aos_word_t low_signed = {{8{operand[7]}}, operand[7:0]};
    wire aos_word_t high_signed = {{8{operand[15]}}, operand[15:8]};
    wire aos_word_t low_unsigned = {8'h00, operand[7:0]};
    wire aos_word_t low_to_high = {operand[7:0], 8'h00};
    // reserved codes give a fixed word, never a stray source
    wire aos_word_t special = (b_index == SP_OPERAND) ? operand :
                              (b_index == SP_MEMORY_IN) ? memory_in :
                              (b_index == SP_IO_IN) ? io_in :
                              (b_index == SP_FLAGS) ? flags :
                              (b_index == SP_LOW_SIGNED) ? low_signed :
                              (b_index == SP_HIGH_SIGNED) ? high_signed :
                              (b_index == SP_LOW_UNSIGNED) ? low_unsigned :
                              (b_index == SP_LOW_TO_HIGH) ? low_to_high :
                              SP_RESERVED_VALUE;
    assign b_bus = (b_sel == B_SRC_GPR) ? reg_value :
                   (b_sel == B_SRC_SPECIAL) ? special :
                   (b_sel == B_SRC_MASK) ? (instr & ~constant_bits) :
                   ~constant_bits;
endmodule // aos_b_select

/* File: aos_operand_select.sv */
// alu operand selection top: microword decode, source latches, avalon slave
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
// Behaviour
// - two operand buses, A and B, each with own selects and different sources
// - A select 00 passes the general register chosen by the A index
// - B select 00 passes the general register chosen by the B index
// - A select 00, B plain: move X01 gives zeros, X1X ones; B 1X passes register
// - A select 10 shifts left; top bit and low bit fill per move control
// - A select 11 shifts right; top bit fill chosen by move control 000-100
// - B select 01 picks operand, memory input, io input or flags word
// - special codes 0100/0101 give low/high operand byte sign-extended
// - special codes 0110/0111 give low byte zero-filled, or moved high
// - with literal or mask, alu mode follows function code bit 1
// - with literal or mask, carry input is forced to zero
// - with literal or mask, no general register writeback happens
module aos_operand_select (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // microword from the sequencer
    input wire logic [aos_pkg::UW_W-1:0] MICROWORD,
    // registered operand buses and alu controls
    output aos_pkg::aos_word_t A_BUS,
    output aos_pkg::aos_word_t B_BUS,
    output logic ALU_MODE,
    output logic [1:0] CARRY_IN_SELECT,
    output logic WRITEBACK_ENABLE,
    // avalon-mm register slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    import aos_pkg::*;

    // source storage
    aos_word_t gpr [0:15];
    aos_word_t pc;
    aos_word_t operand;
    aos_word_t memory_in;
    aos_word_t io_in;
    aos_word_t flags;
    aos_word_t instr;
    logic [1:0] control;

    // microword field extraction, sampled at each edge while the run bit is set
    wire [3:0] alu_function_code = MICROWORD[FF_LSB +: FF_W];
    wire alu_mode_bit = MICROWORD[MF_LSB];
    wire [1:0] carry_in_select = MICROWORD[CF_LSB +: CF_W];
    wire [1:0] destination_store = MICROWORD[DS_LSB +: DS_W];
    wire [2:0] bit_move_control = MICROWORD[SH_LSB +: SH_W];
    wire [3:0] b_register_index = MICROWORD[BB_LSB +: IDX_W];
    wire [3:0] a_register_index = MICROWORD[AA_LSB +: IDX_W];
    wire [1:0] a_source_select = MICROWORD[LA_LSB +: SEL_W];
    wire [1:0] b_source_select = MICROWORD[LB_LSB +: SEL_W];
    // mode, carry, store, extra fields, move and b index form the constant
    wire [15:0] constant_bits = MICROWORD[LIT_LSB +: LIT_W];
    wire literal_used = b_source_select[1];

    // alu control overrides while the constant occupies the fields
    wire next_mode = literal_used ? alu_function_code[FF_MODE_BIT] : alu_mode_bit;
    wire [1:0] next_carry = literal_used ? CARRY_ZERO : carry_in_select;
    wire next_writeback = ~literal_used && (destination_store != 2'h0);
    wire run = control[CTRL_RUN];

    // operand bus selection, one selector per bus
    wire aos_word_t next_a_bus;
    wire aos_word_t next_b_bus;

    aos_a_select u_a_select (
        .a_sel(a_source_select),
        .move(bit_move_control),
        .b_sel(b_source_select),
        .reg_value(gpr[a_register_index]),
        .pc(pc),
        .operand(operand),
        .mul_sign(control[CTRL_MUL_SIGN]),
        .a_bus(next_a_bus)
    );

    aos_b_select u_b_select (
        .b_sel(b_source_select),
        .b_index(b_register_index),
        .constant_bits(constant_bits),
        .reg_value(gpr[b_register_index]),
        .operand(operand),
        .memory_in(memory_in),
        .io_in(io_in),
        .flags(flags),
        .instr(instr),
        .b_bus(next_b_bus)
    );

    // operand buses hold while software has stopped the run bit
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            A_BUS <= WORD_RESET;
            B_BUS <= WORD_RESET;
        end
        else if (run)
        begin
            A_BUS <= next_a_bus;
            B_BUS <= next_b_bus;
        end
    end

    // alu controls share the run gate so they stay aligned with the buses
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            ALU_MODE <= 1'b0;
            CARRY_IN_SELECT <= CARRY_ZERO;
            WRITEBACK_ENABLE <= 1'b0;
        end
        else if (run)
        begin
            ALU_MODE <= next_mode;
            CARRY_IN_SELECT <= next_carry;
            WRITEBACK_ENABLE <= next_writeback;
        end
    end

    // bus handshake: one wait cycle, then completion at waitrequest low
    wire request = AVS_READ || AVS_WRITE;
    wire complete = request && !AVS_WAITREQUEST;
    wire write_hit = AVS_WRITE && complete;
    wire next_waitrequest = !(request && AVS_WAITREQUEST);

    // address decode
    wire gpr_hit = (AVS_ADDRESS[7:6] == OFS_GPR0[7:6]) && (AVS_ADDRESS[1:0] == 2'h0);
    wire [3:0] gpr_index = AVS_ADDRESS[5:2];
    wire pc_hit = AVS_ADDRESS == OFS_PC;
    wire operand_hit = AVS_ADDRESS == OFS_OPERAND;
    wire memory_in_hit = AVS_ADDRESS == OFS_MEMORY_IN;
    wire io_in_hit = AVS_ADDRESS == OFS_IO_IN;
    wire flags_hit = AVS_ADDRESS == OFS_FLAGS;
    wire instr_hit = AVS_ADDRESS == OFS_INSTR;
    wire control_hit = AVS_ADDRESS == OFS_CONTROL;
    wire a_view_hit = AVS_ADDRESS == OFS_A_VIEW;
    wire b_view_hit = AVS_ADDRESS == OFS_B_VIEW;
    wire result_view_hit = AVS_ADDRESS == OFS_RESULT_VIEW;

    // byte-lane merge of the low halfword; upper lanes have no storage
    function automatic aos_word_t merge(input aos_word_t old_value,
                                        input logic [15:0] data,
                                        input logic [1:0] lanes);
        merge = {lanes[1] ? data[15:8] : old_value[15:8],
                 lanes[0] ? data[7:0] : old_value[7:0]};
    endfunction

    // read mux; unmapped addresses read as zero
    wire aos_word_t read_word =
        gpr_hit ? gpr[gpr_index] :
        pc_hit ? pc :
        operand_hit ? operand :
        memory_in_hit ? memory_in :
        io_in_hit ? io_in :
        flags_hit ? flags :
        instr_hit ? instr :
        control_hit ? {14'h0000, control} :
        a_view_hit ? A_BUS :
        b_view_hit ? B_BUS :
        result_view_hit ? {11'h000, WRITEBACK_ENABLE, CARRY_IN_SELECT, ALU_MODE, run} :
        WORD_RESET;
    wire [1:0] lanes = AVS_BYTEENABLE[1:0];
    wire [15:0] wdata = AVS_WRITEDATA[15:0];

    // waitrequest: one wait cycle per access, high again after completion
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            AVS_WAITREQUEST <= 1'b1;
        end
        else
        begin
            AVS_WAITREQUEST <= next_waitrequest;
        end
    end

    // read data loaded at the first edge so it stands at the completing edge
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            AVS_READDATA <= 32'h00000000;
        end
        else if (AVS_READ && AVS_WAITREQUEST)
        begin
            AVS_READDATA <= {16'h0000, read_word};
        end
    end

    // general registers, one writer per entry
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_gpr
            wire entry_write = write_hit && gpr_hit && (gpr_index == 4'(gi));
            always_ff @(posedge CLOCK)
            begin
                if (!RESETN)
                begin
                    gpr[gi] <= WORD_RESET;
                end
                else if (entry_write)
                begin
                    gpr[gi] <= merge(gpr[gi], wdata, lanes);
                end
            end
        end
    endgenerate

    // program counter, loaded by software
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            pc <= WORD_RESET;
        end
        else if (write_hit && pc_hit)
        begin
            pc <= merge(pc, wdata, lanes);
        end
    end

    // operand latch; also feeds shift fills and byte views
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            operand <= WORD_RESET;
        end
        else if (write_hit && operand_hit)
        begin
            operand <= merge(operand, wdata, lanes);
        end
    end

    // memory input latch
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            memory_in <= WORD_RESET;
        end
        else if (write_hit && memory_in_hit)
        begin
            memory_in <= merge(memory_in, wdata, lanes);
        end
    end

    // io input latch
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            io_in <= WORD_RESET;
        end
        else if (write_hit && io_in_hit)
        begin
            io_in <= merge(io_in, wdata, lanes);
        end
    end

    // flags word, no flag logic of its own here
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            flags <= WORD_RESET;
        end
        else if (write_hit && flags_hit)
        begin
            flags <= merge(flags, wdata, lanes);
        end
    end

    // instruction register, source of the masked b operand
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            instr <= WORD_RESET;
        end
        else if (write_hit && instr_hit)
        begin
            instr <= merge(instr, wdata, lanes);
        end
    end

    // control bits live in lane 0 only; a lane 1 write leaves them alone
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            control <= CONTROL_RESET;
        end
        else if (write_hit && control_hit && lanes[0])
        begin
            control <= wdata[1:0];
        end
    end
endmodule // aos_operand_select

/* File: aos_operand_select_assertions.sv */
// concurrent checks on the operand selection top ports
`timescale 1ns/10ps
module aos_operand_select_assertions
    import aos_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // microword and registered outputs
    input wire logic [UW_W-1:0] MICROWORD,
    input wire aos_word_t A_BUS,
    input wire aos_word_t B_BUS,
    input wire logic ALU_MODE,
    input wire logic [1:0] CARRY_IN_SELECT,
    input wire logic WRITEBACK_ENABLE,
    // register bus writes, watched for the run bit
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic AVS_WAITREQUEST
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);
    // field views of the microword
    wire [1:0] la = MICROWORD[LA_LSB +: SEL_W];
    wire [1:0] lb = MICROWORD[LB_LSB +: SEL_W];
    wire [2:0] sh = MICROWORD[SH_LSB +: SH_W];
    wire [3:0] bb = MICROWORD[BB_LSB +: IDX_W];
    wire [3:0] ff = MICROWORD[FF_LSB +: FF_W];
    wire [15:0] lit = MICROWORD[LIT_LSB +: LIT_W];
    wire ctl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_CONTROL
        && AVS_BYTEENABLE[0];
    logic run;
    logic live;
    // run is internal, so shadow it; outputs only follow words taken while running
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
            run <= CONTROL_RESET[CTRL_RUN];
        else if (ctl_wr)
            run <= AVS_WRITEDATA[CTRL_RUN];
        live <= RESETN && run;
    end
    chk_lit_value: assert property (live && $past(lb) == B_SRC_LITERAL |-> B_BUS == ~$past(lit))
        else $error("literal operand wrong");
    chk_lit_mode: assert property (live && $past(lb[1]) |-> ALU_MODE == $past(ff[FF_MODE_BIT]))
        else $error("forced mode wrong");
    chk_carry_zero: assert property (live && $past(lb[1]) |-> CARRY_IN_SELECT == CARRY_ZERO)
        else $error("carry not forced to zero");
    chk_no_writeback: assert property (live && $past(lb[1]) |-> !WRITEBACK_ENABLE)
        else $error("writeback with constant operand");
    chk_a_zeros: assert property (live && $past(la) == 2'h0 && !$past(lb[1])
        && $past(sh[1:0]) == 2'h1 |-> A_BUS == 16'h0000)
        else $error("a bus not all zeros");
    chk_a_ones: assert property (live && $past(la) == 2'h0 && !$past(lb[1])
        && $past(sh[1]) |-> A_BUS == 16'hFFFF)
        else $error("a bus not all ones");
    chk_sign_ext: assert property (live && $past(lb) == B_SRC_SPECIAL
        && $past(bb) == SP_LOW_SIGNED |-> B_BUS[15:8] == {8{B_BUS[7]}})
        else $error("low byte not sign extended");
    chk_reserved_code: assert property (live && $past(lb) == B_SRC_SPECIAL
        && $past(bb[3]) |-> B_BUS == SP_RESERVED_VALUE)
        else $error("reserved special code not fixed");
    // main scenarios
    cover property (live && $past(lb) == B_SRC_MASK);
    cover property (live && $past(la) == A_SRC_SHR);
    cover property (ctl_wr);
endmodule // aos_operand_select_assertions

bind aos_operand_select aos_operand_select_assertions u_chk (.CLOCK(CLOCK), .RESETN(RESETN),
    .MICROWORD(MICROWORD), .A_BUS(A_BUS), .B_BUS(B_BUS), .ALU_MODE(ALU_MODE),
    .CARRY_IN_SELECT(CARRY_IN_SELECT), .WRITEBACK_ENABLE(WRITEBACK_ENABLE),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WAITREQUEST(AVS_WAITREQUEST));

/* File: aos_seq_model.sv */
// behavioural sequencer presenting one microword per cycle
`timescale 1ns/10ps
module aos_seq_model
    import aos_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // microword towards the block
    output logic [UW_W-1:0] microword
);
    logic [UW_W-1:0] next_word;
    // bench hands over the word for the coming cycle
    task automatic present(input logic [UW_W-1:0] w);
        next_word = w;
    endtask
    initial
    begin
        next_word = '0;
    end
    // the whole word changes just after an edge, never mid-cycle
    always @(posedge clock)
    begin
        if (!resetn)
            microword <= '0;
        else
            microword <= next_word;
    end
endmodule // aos_seq_model

/* File: tb.sv */
// self-checking bench for the alu operand selection block
`timescale 1ns/10ps
module tb;
    import aos_pkg::*;
    logic clock;
    logic resetn;
    logic [UW_W-1:0] mw;
    aos_word_t a_bus;
    aos_word_t b_bus;
    logic mode;
    logic [1:0] carry;
    logic wb;
    logic [7:0] adr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic waitreq;
    int bad_count;
    int samples_checked;
    aos_word_t gpr [16];
    aos_word_t src [4];
    aos_word_t pcv;
    aos_word_t instr;
    logic ms;
    logic [31:0] q;
    logic [UW_W-1:0] w;
    aos_seq_model seq (.clock(clock), .resetn(resetn), .microword(mw));
    aos_operand_select uut (.CLOCK(clock), .RESETN(resetn), .MICROWORD(mw), .A_BUS(a_bus),
        .B_BUS(b_bus), .ALU_MODE(mode), .CARRY_IN_SELECT(carry), .WRITEBACK_ENABLE(wb),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq));
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one avalon access; request held until waitrequest is seen low at an edge,
    // read data taken and request released at that same edge
    task automatic bus(input logic w_n, input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        adr <= a;
        wr <= w_n;
        rd <= !w_n;
        wdata <= {16'h0000, d};
        @(posedge clock);
        while (waitreq !== 1'b0)
            @(posedge clock);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    function automatic aos_word_t exp_a(input logic [UW_W-1:0] u);
        logic [2:0] sh;
        aos_word_t r;
        logic [7:0] fr;
        logic [3:0] fl;
        sh = u[SH_LSB +: SH_W];
        r = gpr[u[AA_LSB +: IDX_W]];
        fr = {4'h0, src[0][0], r[15], r[0], ms};
        fl = {1'b0, src[0][15], r[15], 1'b0};
        case (u[LA_LSB +: SEL_W])
            2'h1: return pcv;
            2'h2: return {sh[2] ? r[15] : r[14], r[13:0], fl[sh[1:0]]};
            2'h3: return {fr[sh], r[15:1]};
            default:
                if (!u[LB_LSB + 1] && sh[1])
                    return 16'hFFFF;
                else if (!u[LB_LSB + 1] && sh[1:0] == 2'h1)
                    return 16'h0000;
                else
                    return r;
        endcase
    endfunction
    function automatic aos_word_t exp_b(input logic [UW_W-1:0] u);
        logic [3:0] bb;
        aos_word_t o;
        aos_word_t lit;
        bb = u[BB_LSB +: IDX_W];
        o = src[0];
        lit = u[LIT_LSB +: LIT_W];
        case (u[LB_LSB +: SEL_W])
            2'h0: return gpr[bb];
            2'h2: return instr & ~lit;
            2'h3: return ~lit;
            default:
                case (bb)
                    4'h4: return {{8{o[7]}}, o[7:0]};
                    4'h5: return {{8{o[15]}}, o[15:8]};
                    4'h6: return {8'h00, o[7:0]};
                    4'h7: return {o[7:0], 8'h00};
                    default: return bb[3] ? 16'h0000 : src[bb[1:0]];
                endcase
        endcase
    endfunction
    // present a word, then compare every output one cycle after it is taken
    task automatic step(input logic [UW_W-1:0] u);
        logic lit;
        lit = u[LB_LSB + 1];
        seq.present(u);
        repeat (2) @(posedge clock);
        #1;
        check("a_bus", a_bus, exp_a(u));
        check("b_bus", b_bus, exp_b(u));
        check("alu_mode", mode, lit ? u[FF_LSB + 1] : u[MF_LSB]);
        check("carry", carry, lit ? 2'h0 : u[CF_LSB +: CF_W]);
        check("writeback", wb, !lit && u[DS_LSB +: DS_W] != 2'h0);
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        final_report();
    end
    initial
    begin
        resetn = 1'b0;
        adr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0000_0000;
        bad_count = 0;
        samples_checked = 0;
        pcv = 16'h1234;
        src = '{16'h80F3, 16'h0F0F, 16'hC3C3, 16'h5AA5};
        instr = 16'hB6E9;
        ms = 1'b0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        bus(1'b0, OFS_CONTROL, 16'h0000);
        check("control_reset", q, {30'h0, CONTROL_RESET});
        bus(1'b0, OFS_PC, 16'h0000);
        check("pc_reset", q, {16'h0000, WORD_RESET});
        for (int n = 0; n < 16; n++)
        begin
            gpr[n] = 16'h4B2D ^ {4{4'(n)}};
            bus(1'b1, 8'(OFS_GPR0 + 4 * n), gpr[n]);
        end
        bus(1'b1, OFS_PC, pcv);
        bus(1'b1, OFS_OPERAND, src[0]);
        bus(1'b1, OFS_MEMORY_IN, src[1]);
        bus(1'b1, OFS_IO_IN, src[2]);
        bus(1'b1, OFS_FLAGS, src[3]);
        bus(1'b1, OFS_INSTR, instr);
        bus(1'b0, 8'(OFS_GPR0 + 36), 16'h0000);
        check("gpr9", q, {16'h0000, gpr[9]});
        bus(1'b0, 8'hFC, 16'h0000);
        check("unmapped", q, 32'h0000_0000);
        // every select, move code and special code, with multiply sign low then high
        for (int m = 0; m < 2; m++)
        begin
            ms = 1'(m);
            bus(1'b1, OFS_CONTROL, {14'h0, ms, 1'b1});
            for (int k = 0; k < 2048; k++)
            begin
                w = '0;
                w[LA_LSB +: SEL_W] = k[10:9];
                w[SH_LSB +: SH_W] = k[8:6];
                w[LB_LSB +: SEL_W] = k[5:4];
                w[BB_LSB +: IDX_W] = k[3:0];
                w[AA_LSB +: IDX_W] = k[3:0] ^ 4'h5;
                w[FF_LSB +: FF_W] = {k[10:9], k[7:6]};
                w[MF_LSB] = k[6];
                w[CF_LSB +: CF_W] = k[5:4];
                w[DS_LSB +: DS_W] = k[7:6];
                step(w);
            end
        end
        bus(1'b1, OFS_A_VIEW, 16'hFFFF);
        bus(1'b0, OFS_A_VIEW, 16'h0000);
        check("a_view", q, {16'h0000, exp_a(w)});
        bus(1'b0, OFS_B_VIEW, 16'h0000);
        check("b_view", q, {16'h0000, exp_b(w)});
        bus(1'b0, OFS_RESULT_VIEW, 16'h0000);
        check("result_view", q, {27'h0, 1'b0, 2'h0, w[FF_LSB + FF_MODE_BIT], 1'b1});
        // with run cleared the outputs keep their last values
        bus(1'b1, OFS_CONTROL, 16'h0000);
        seq.present(~w);
        repeat (4) @(posedge clock);
        #1;
        check("a_hold", a_bus, exp_a(w));
        final_report();
    end
endmodule // tb
